// >>> hw/program_space_access_mapper.sv
/*
 * Program space access mapper: takes fetch, table and data accesses
 * from the core, builds program addresses, drives program memory,
 * steers read and write data and inserts the window wait cycles.
 * Page and enable registers sit on APB. Program memory is assumed to
 * return read data in the same cycle as its registered address.
 */
`timescale 1ns/1ps
`default_nettype none
module program_space_access_mapper
   import psam_pkg::*;
#(
   parameter int PC_W = 23, // Program counter width.
   parameter int EA_W = 16  // Data effective address width.
) (
   // Clock and reset.
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave.
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Core request.
   input  wire logic                   req_valid,
   output logic                        req_ready,
   input  wire psam_pkg::access_kind_t req_kind,
   input  wire logic [PC_W-1:0]        req_pc,
   input  wire logic [EA_W-1:0]        req_ea,
   input  wire logic                   req_write,
   input  wire logic                   req_high,
   input  wire logic                   req_byte,
   input  wire logic [15:0]            req_wdata,
   // Core instruction context.
   input  wire psam_pkg::instr_class_t req_class,
   input  wire logic                   in_repeat,
   input  wire logic                   rpt_first,
   input  wire logic                   rpt_last,
   input  wire logic                   rpt_int_exit,
   input  wire logic                   rpt_reentry,
   // Core response.
   output logic                        resp_valid,
   output logic                        resp_mapped,
   output logic      [15:0]            resp_data,
   output logic      [23:0]            resp_instr,
   // Program memory.
   output logic      [23:0]            pm_addr,
   output logic                        pm_rd,
   output logic                        pm_wr,
   output logic      [23:0]            pm_wdata,
   output logic      [2:0]             pm_wbe,
   input  wire logic [23:0]            pm_rdata
);
   // The address builder and steering are written for these widths.
   if (PC_W != 23 || EA_W != 16) begin : g_width_check
      $error("program_space_access_mapper needs PC_W 23 and EA_W 16");
   end

   // Software registers.
   logic [7:0]  table_page;  // Table page select.
   logic [7:0]  window_page; // Window page select.
   logic        win_enable;  // Program window enable.

   // Sequencer state and held request.
   seq_state_t  state;       // Current state.
   seq_state_t  next_state;  // Next state.
   logic [1:0]  wait_cnt;    // Remaining extra cycles.
   logic        hold_hit;    // Held request maps through the window.
   logic        hold_high;   // Held request is a high table op.
   logic        hold_byte;   // Held request is a byte op.
   logic        hold_bsel;   // Held byte-select bit.
   access_kind_t hold_kind;  // Held access kind.

   // APB decode.
   wire apb_setup  = psel & ~penable;
   wire apb_access = psel & penable;
   wire apb_wr     = apb_access & pwrite;
   wire sel_tpage  = (paddr == OFS_TABLE_PAGE);
   wire sel_wpage  = (paddr == OFS_WINDOW_PAGE);
   wire sel_ctl    = (paddr == OFS_CONTROL);
   wire sel_sts    = (paddr == OFS_STATUS);
   wire sel_any    = sel_tpage | sel_wpage | sel_ctl | sel_sts;

   // Window redirect: data access, EA MSB set, enable set.
   wire win_hit    = (req_kind == KIND_DATA) & req_ea[EA_MSB_BIT] &
                     win_enable;
   // Table and fetch go to program memory; data only on a hit.
   wire to_pm      = (req_kind != KIND_DATA) | win_hit;
   // Only table ops may write program memory; the window is read only.
   wire is_tbl_wr  = (req_kind == KIND_TABLE) & req_write;
   wire accept     = req_valid & req_ready;

   // Edge iterations of a repeat loop pay the long penalty.
   wire rpt_edge   = rpt_first | rpt_last | rpt_int_exit | rpt_reentry;
   // Cheap classes pay one cycle outside a loop, others two.
   wire cls_short  = (req_class == CLS_MAC_PREF) |
                     (req_class == CLS_MOVE) |
                     (req_class == CLS_DBL_MOVE);
   wire [1:0] extra_out = cls_short ? EXTRA_SHORT : EXTRA_LONG;
   wire [1:0] extra_in  = rpt_edge ? EXTRA_LONG : EXTRA_NONE;
   wire [1:0] extra     = ~win_hit ? EXTRA_NONE :
                          in_repeat ? extra_in : extra_out;

   // Built address and steered read data.
   logic [23:0] build_addr; // Program address for the request.
   logic [15:0] steer_data; // Data word from the program word.

   // Address construction for all three access kinds.
   psam_addr_build u_addr (
      .kind        (req_kind),
      .pc          (req_pc),
      .ea          (req_ea),
      .table_page  (table_page),
      .window_page (window_page),
      .prog_addr   (build_addr)
   );

   // Read steering; window reads go as low word or low byte reads.
   psam_read_steer u_steer (
      .prog_word (pm_rdata),
      .high      (hold_high),
      .byte_op   (hold_byte),
      .byte_sel  (hold_bsel),
      .data_word (steer_data)
   );

   // Write lanes: low ops hit bytes 0 and 1, high ops byte 2.
   wire [2:0] lanes_low  = req_byte ? (req_ea[0] ? 3'h2 : 3'h1) : 3'h3;
   wire [2:0] lanes_high = (req_byte & req_ea[0]) ? 3'h0 : 3'h4;
   wire [2:0] wr_lanes   = req_high ? lanes_high : lanes_low;
   // Byte data is repeated on both low lanes; high ops put it on the high lane only.
   wire [7:0] wr_byte    = req_byte ? req_wdata[7:0] : req_wdata[7:0];
   wire [23:0] wr_word   = req_high ? {req_wdata[7:0], 16'h0000}
                         : req_byte ? {8'h00, wr_byte, wr_byte}
                                    : {8'h00, req_wdata};

   // APB answers in its access cycle, no wait states.
   assign pready    = 1'b1;
   assign req_ready = (state == ST_IDLE);

   // Status word: last program address, busy and window hit flags.
   wire [31:0] sts_word = {6'h00, hold_hit, (state != ST_IDLE),
                           pm_addr};
   wire [31:0] rd_mux   = sel_tpage ? {24'h000000, table_page} :
                          sel_wpage ? {24'h000000, window_page} :
                          sel_ctl   ? {31'h00000000, win_enable} :
                          sel_sts   ? sts_word : 32'h00000000;

   // Read data and error are registered at the setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (apb_setup) begin
         prdata  <= pwrite ? 32'h00000000 : rd_mux;
         // Unmapped addresses and writes to status are refused.
         pslverr <= ~sel_any | (pwrite & sel_sts);
      end
   end

   // Register writes take effect at the access edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_page  <= RST_PAGE;
         window_page <= RST_PAGE;
         win_enable  <= RST_WIN_EN;
      end else if (apb_wr) begin
         // The table page MSB selects configuration space.
         if (sel_tpage) begin
            table_page <= pwdata[7:0];
         end
         // Window page becomes address bits 22 to 15.
         if (sel_wpage) begin
            window_page <= pwdata[7:0];
         end
         if (sel_ctl) begin
            win_enable <= pwdata[CTL_WIN_EN_BIT];
         end
      end
   end

   // Next state: access, then optional extra cycles, then idle.
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (accept) begin
               next_state = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            // Window cost is spent as wait cycles.
            if (wait_cnt != EXTRA_NONE) begin
               next_state = ST_WAIT;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_WAIT: begin
            if (wait_cnt == EXTRA_SHORT) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Wait counter loaded at accept, counted down while waiting.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt <= EXTRA_NONE;
      end else if (accept) begin
         wait_cnt <= extra;
      end else if (state == ST_WAIT) begin
         wait_cnt <= wait_cnt - EXTRA_SHORT;
      end
   end

   // Held request shape for steering and status.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_hit  <= 1'b0;
         hold_high <= 1'b0;
         hold_byte <= 1'b0;
         hold_bsel <= 1'b0;
         hold_kind <= KIND_FETCH;
      end else if (accept) begin
         hold_hit  <= win_hit;
         // Window reads always return the low word or a low byte.
         hold_high <= req_high & (req_kind == KIND_TABLE);
         hold_byte <= req_byte & (req_kind != KIND_FETCH);
         hold_bsel <= req_ea[0];
         hold_kind <= req_kind;
      end
   end

   // Program memory strobes: one cycle, in the access state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_addr  <= 24'h000000;
         pm_rd    <= 1'b0;
         pm_wr    <= 1'b0;
         pm_wdata <= 24'h000000;
         pm_wbe   <= 3'h0;
      end else if (accept) begin
         // Untouched when the access stays in data space.
         if (to_pm) begin
            pm_addr <= build_addr;
         end
         pm_rd    <= to_pm & ~is_tbl_wr;
         pm_wr    <= is_tbl_wr;
         pm_wdata <= is_tbl_wr ? wr_word : 24'h000000;
         pm_wbe   <= is_tbl_wr ? wr_lanes : 3'h0;
      end else begin
         pm_rd  <= 1'b0;
         pm_wr  <= 1'b0;
         pm_wbe <= 3'h0;
      end
   end

   // Read data captured in the access cycle.
   wire take_read = (state == ST_ACCESS) & pm_rd;
   wire finish    = (state != ST_IDLE) & (next_state == ST_IDLE);

   // Response registers: data held until the next capture.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resp_data  <= 16'h0000;
         resp_instr <= 24'h000000;
      end else if (state == ST_ACCESS) begin
         resp_data  <= (take_read & (hold_kind != KIND_FETCH)) ?
                       steer_data : 16'h0000;
         resp_instr <= (take_read & (hold_kind == KIND_FETCH)) ?
                       pm_rdata : 24'h000000;
      end
   end

   // Response strobe and mapping flag at the end of a request.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resp_valid  <= 1'b0;
         resp_mapped <= 1'b0;
      end else begin
         resp_valid  <= finish;
         if (finish) begin
            resp_mapped <= (hold_kind != KIND_DATA) | hold_hit;
         end
      end
   end
endmodule // program_space_access_mapper
`default_nettype wire

// >>> hw/psam_pkg.sv
/*
 * Shared constants for the program space access mapper: register map,
 * field positions, reset values, access kinds and wait-cycle counts.
 * Assumes a 32-bit APB register bus and a core that issues one access
 * at a time on the same clock.
 */
// What this block does
// - Program space of 4M words, three address sources.
// - Program word addresses step by two.
// - Non-table accesses stay in user space.
// - Bit 23 set only by table accesses.
// - Table address is page over 16-bit EA.
// - Window address is zero, page, EA<14:0>.
// - Word low table read returns P<15:0>.
// - Byte low table read selects by EA<0>.
// - Word high read gives P<23:16>, upper zero.
// - Byte high read gives P<23:16> or zero.
// - Only high table ops reach upper byte.
// - Window hit needs EA MSB and enable bit.
// - Upper 32 KB maps to any 16K page.
// - Window reads return low 16 bits only.
// - Window suspended during table operations.
// - Outside repeat: one or two extra cycles.
// - Inside repeat: two extra on edge iterations.
// - Window page supplies address bits 22 to 15.
package psam_pkg;
   // Register byte offsets on the APB bus.
   localparam logic [11:0] OFS_TABLE_PAGE  = 12'h000;
   localparam logic [11:0] OFS_WINDOW_PAGE = 12'h004;
   localparam logic [11:0] OFS_CONTROL     = 12'h008;
   localparam logic [11:0] OFS_STATUS      = 12'h00c;
   // Reset values of the software registers.
   localparam logic [7:0]  RST_PAGE        = 8'h00;
   localparam logic        RST_WIN_EN      = 1'b0;
   // Field positions.
   localparam int          CTL_WIN_EN_BIT  = 0;
   localparam int          STS_BUSY_BIT    = 24;
   localparam int          STS_HIT_BIT     = 25;
   localparam int          ADDR_TOP_BIT    = 23;
   localparam int          EA_MSB_BIT      = 15;
   localparam int          PAGE_MSB_BIT    = 7;
   // Extra cycles that a window access costs.
   localparam logic [1:0]  EXTRA_NONE      = 2'h0;
   localparam logic [1:0]  EXTRA_SHORT     = 2'h1;
   localparam logic [1:0]  EXTRA_LONG      = 2'h2;
   // Kinds of access that the core issues.
   typedef enum logic [1:0] {
      KIND_FETCH = 2'h0,
      KIND_TABLE = 2'h1,
      KIND_DATA  = 2'h2
   } access_kind_t;
   // Instruction classes that set the window cost.
   typedef enum logic [1:0] {
      CLS_OTHER    = 2'h0,
      CLS_MAC_PREF = 2'h1,
      CLS_MOVE     = 2'h2,
      CLS_DBL_MOVE = 2'h3
   } instr_class_t;
   // Sequencer states, Gray coded along idle, access, wait.
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ACCESS = 2'b01,
      ST_WAIT   = 2'b11
   } seq_state_t;
endpackage

// >>> hw/psam_addr_build.sv
/*
 * Program address builder: forms the 24-bit program address for a
 * fetch, a table access or a data-window access.
 * Assumes the caller picks the kind and holds inputs stable.
 */
`timescale 1ns/1ps
`default_nettype none
module psam_addr_build
   import psam_pkg::*;
(
   // Access selection.
   input  wire psam_pkg::access_kind_t kind,
   // Address sources.
   input  wire logic [22:0]           pc,
   input  wire logic [15:0]           ea,
   input  wire logic [7:0]            table_page,
   input  wire logic [7:0]            window_page,
   // Result.
   output logic      [23:0]           prog_addr
);
   // Fetch address keeps bit 0 clear so words step by two.
   wire [23:0] fetch_addr  = {1'b0, pc[22:1], 1'b0};
   // Table page sits above the whole EA; page MSB picks config space.
   wire [23:0] table_addr  = {table_page, ea};
   // Window page supplies bits 22 to 15 above the low 15 EA bits.
   wire [23:0] window_addr = {1'b0, window_page, ea[14:0]};

   // Only the table path can carry bit 23 through.
   assign prog_addr = (kind == KIND_FETCH) ? fetch_addr :
                      (kind == KIND_TABLE) ? table_addr : window_addr;
endmodule // psam_addr_build
`default_nettype wire

// >>> hw/psam_read_steer.sv
/*
 * Read steering: turns a 24-bit program word into the 16-bit data
 * result of a table read or a window read.
 * Assumes window reads arrive with high low.
 */
`timescale 1ns/1ps
`default_nettype none
module psam_read_steer (
   // Program word and operation shape.
   input  wire logic [23:0] prog_word,
   input  wire logic        high,
   input  wire logic        byte_op,
   input  wire logic        byte_sel,
   // Steered data word.
   output logic      [15:0] data_word
);
   // Low byte picked by the byte-select address bit.
   wire [7:0] low_byte  = byte_sel ? prog_word[15:8] : prog_word[7:0];
   // Upper byte is only there for byte select zero.
   wire [7:0] high_byte = byte_sel ? 8'h00 : prog_word[23:16];
   // Word results of each half.
   wire [15:0] low_word  = prog_word[15:0];
   wire [15:0] high_word = {8'h00, prog_word[23:16]};

   // Only the high forms expose P<23:16>.
   assign data_word = high ? (byte_op ? {8'h00, high_byte}
                                      : high_word)
                           : (byte_op ? {8'h00, low_byte}
                                      : low_word);
endmodule // psam_read_steer
`default_nettype wire

// >>> dv/psam_pm_model.sv
/* Program memory model for the mapper bench.
   Assumes reads are combinational on pm_addr while pm_rd is high. */
`timescale 1ns/1ps
`default_nettype none
module psam_pm_model (
   // Memory port of the mapper.
   input  wire logic [23:0] pm_addr,
   input  wire logic        pm_rd,
   output logic      [23:0] pm_rdata
);
   // Each word is its address scrambled; outside a read the bus shows
   // the inverse, so stale data cannot pass for a good read.
   wire [23:0] word = pm_addr ^ 24'h5a3c96;
   assign pm_rdata = pm_rd ? word : ~word;
endmodule // psam_pm_model
`default_nettype wire

// >>> dv/psam_monitor.sv
/* Port checker for the program space access mapper.
   Assumes zero-wait APB and one core request outstanding. */
`timescale 1ns/1ps
`default_nettype none
module psam_monitor
   import psam_pkg::*;
#(parameter int PC_W = 23, parameter int EA_W = 16)
(
   // Clock, reset and APB.
   input wire logic pclk, presetn, psel, penable, pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Core side.
   input wire logic req_valid, req_ready, req_write, req_high, req_byte,
   input wire psam_pkg::access_kind_t req_kind,
   input wire psam_pkg::instr_class_t req_class,
   input wire logic [PC_W-1:0] req_pc,
   input wire logic [EA_W-1:0] req_ea,
   input wire logic [15:0] req_wdata, resp_data,
   input wire logic in_repeat, rpt_first, rpt_last, rpt_int_exit,
   input wire logic rpt_reentry, resp_valid, resp_mapped,
   // Program memory.
   input wire logic [23:0] pm_addr, pm_wdata, pm_rdata,
   input wire logic pm_rd, pm_wr,
   input wire logic [2:0] pm_wbe
);
   logic [7:0]  tpage, wpage;  // Shadow page registers.
   logic        wen;           // Shadow window enable.
   logic [22:0] c_pc;          // Request fields kept at accept.
   logic [15:0] c_ea, c_wd;
   logic        c_hi, c_by, c_tab;
   logic [23:0] c_rd;          // Last word read from memory.
   wire acc = req_valid && req_ready;
   wire apw = psel && penable && pwrite;
   wire hit = req_kind == KIND_DATA && req_ea[15] && wen;
   wire rpt = rpt_first | rpt_last | rpt_int_exit | rpt_reentry;
   // Shadows follow APB writes so addresses can be predicted.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tpage <= RST_PAGE;
         wpage <= RST_PAGE;
         wen   <= RST_WIN_EN;
      end else if (apw) begin
         if (paddr == OFS_TABLE_PAGE) tpage <= pwdata[7:0];
         if (paddr == OFS_WINDOW_PAGE) wpage <= pwdata[7:0];
         if (paddr == OFS_CONTROL) wen <= pwdata[CTL_WIN_EN_BIT];
      end
   end
   // Capture of the accepted request and of memory read data.
   always_ff @(posedge pclk) begin
      if (acc) begin
         c_pc  <= req_pc[22:0];
         c_ea  <= req_ea[15:0];
         c_wd  <= req_wdata;
         c_hi  <= req_high;
         c_by  <= req_byte;
         c_tab <= req_kind == KIND_TABLE;
      end
      if (pm_rd) c_rd <= pm_rdata;
   end
   // Expected table read result from the captured shape.
   // Shape bits come in as arguments so the property samples them too.
   function automatic logic [15:0] steer(input logic [23:0] w,
                                         input logic hi, by, bs);
      if (!hi) return by ? {8'h00, bs ? w[15:8] : w[7:0]} : w[15:0];
      return (by && bs) ? 16'h0000 : {8'h00, w[23:16]};
   endfunction
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_tab; acc && req_kind == KIND_TABLE; endsequence
   sequence s_hit; acc && hit && !req_write; endsequence
   sequence s_late; !resp_valid [*3] ##1 resp_valid; endsequence
   AST_FETCH_ADDR: assert property (acc && req_kind == KIND_FETCH |=>
      pm_rd && pm_addr == {1'b0, c_pc[22:1], 1'b0})
      else $error("fetch address wrong");
   AST_TABLE_ADDR: assert property (s_tab |=>
      (pm_rd || pm_wr) && pm_addr == {tpage, c_ea})
      else $error("table address wrong");
   AST_TOP_BIT: assert property ((pm_rd || pm_wr) && !c_tab |->
      !pm_addr[23]) else $error("address bit 23 set");
   AST_WIN_ADDR: assert property (s_hit |=> pm_rd &&
      pm_addr == {1'b0, wpage, c_ea[14:0]}) else $error("window address");
   AST_NO_HIT: assert property (acc && req_kind == KIND_DATA && !hit |=>
      !pm_rd && !pm_wr ##1 resp_valid && !resp_mapped && resp_data == 16'h0)
      else $error("plain data access reached memory");
   AST_TABLE_READ: assert property (s_tab and !req_write |=>
      ##1 resp_valid && resp_mapped &&
      resp_data == steer(c_rd, c_hi, c_by, c_ea[0]))
      else $error("table read data wrong");
   AST_COST_SHORT: assert property (s_hit and !in_repeat &&
      req_class != CLS_OTHER |=> !resp_valid ##1 !resp_valid ##1
      resp_valid && resp_data == c_rd[15:0]) else $error("short cost");
   AST_COST_LONG: assert property (s_hit and
      (in_repeat ? rpt : req_class == CLS_OTHER) |=> s_late ##0
      resp_data == c_rd[15:0]) else $error("long cost");
   AST_RPT_MID: assert property (s_hit and in_repeat && !rpt |=>
      !resp_valid ##1 resp_valid) else $error("repeat cost");
   AST_WR_HIGH: assert property (s_tab and req_write && req_high &&
      !req_byte |=> pm_wr && pm_wbe == 3'b100 && pm_wdata[23:16] == c_wd[7:0])
      else $error("high write lanes");
endmodule // psam_monitor
bind program_space_access_mapper psam_monitor
   #(.PC_W(PC_W), .EA_W(EA_W)) u_mon (.*);
`default_nettype wire

// >>> dv/program_space_access_mapper_tb.sv
/* Self-checking bench for the program space access mapper.
   Assumes zero-wait APB and the memory model beside the design. */
`timescale 1ns/1ps
`default_nettype none
module program_space_access_mapper_tb;
   import psam_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic req_valid, req_ready, req_write, req_high, req_byte;
   access_kind_t req_kind;
   instr_class_t req_class;
   logic [22:0] req_pc;
   logic [15:0] req_ea, req_wdata, resp_data, r_data;
   logic in_repeat, rpt_first, rpt_last, rpt_int_exit, rpt_reentry;
   logic resp_valid, resp_mapped, pm_rd, pm_wr, r_map;
   logic [23:0] resp_instr, pm_addr, pm_wdata, pm_rdata, w;
   logic [2:0] pm_wbe, r_wbe;
   int err_count, check_count, r_cyc;
   program_space_access_mapper u_dut (.*);
   psam_pm_model u_mem (.*);
   // Free-running 10 MHz clock.
   initial begin
      pclk = 0;
      forever #50 pclk = ~pclk;
   end
   // Expected memory content, kept apart from the model's own copy.
   function automatic logic [23:0] mw(input logic [23:0] a);
      return a ^ 24'h5a3c96;
   endfunction
   // Compares and counts; a mismatch is reported at once.
   task automatic chk(input logic [31:0] got, exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic hang(input string what);
      err_count++;
      $display("[ERR] %0t timeout in %s", $time, what);
      tally_and_finish();
   endtask
   // One APB transfer: setup, access until pready, then release.
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, exp, input logic err);
      int i;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) hang("apb");
      if (!wr) chk(prdata, exp, "prdata");
      chk({31'h0, pslverr}, {31'h0, err}, "pslverr");
      psel <= 0;
      penable <= 0;
   endtask
   // One core request held until accepted, then its response awaited.
   task automatic op(input access_kind_t k, input logic [22:0] pc,
      input logic [15:0] ea, input logic [2:0] f, input instr_class_t c,
      input logic [4:0] r);
      int i;
      @(posedge pclk);
      req_kind <= k;
      req_pc <= pc;
      req_ea <= ea;
      {req_write, req_high, req_byte} <= f;
      req_class <= c;
      {in_repeat, rpt_first, rpt_last, rpt_int_exit, rpt_reentry} <= r;
      req_wdata <= ea ^ 16'h3c3c;
      req_valid <= 1;
      r_wbe = 3'b000;
      for (i = 0; i < 16; i++) begin
         @(negedge pclk);
         if (req_ready === 1'b1) break;
      end
      if (i == 16) hang("accept");
      @(posedge pclk);
      req_valid <= 0;
      for (r_cyc = 1; r_cyc < 16; r_cyc++) begin
         @(negedge pclk);
         if (pm_wr === 1'b1) r_wbe = pm_wbe;
         if (resp_valid === 1'b1) break;
      end
      if (r_cyc == 16) hang("response");
      r_data = resp_data;
      r_map = resp_mapped;
   endtask
   // Register reset values, read back and refused places.
   task automatic t_regs;
      apb(0, OFS_TABLE_PAGE, 0, 0, 0);
      apb(0, OFS_CONTROL, 0, 0, 0);
      apb(0, OFS_STATUS, 0, 0, 0);
      apb(1, OFS_WINDOW_PAGE, 32'h1a5, 0, 0);
      apb(0, OFS_WINDOW_PAGE, 0, 32'ha5, 0);
      apb(1, OFS_STATUS, 32'hff, 0, 1);
      apb(0, 12'h010, 0, 0, 1);
   endtask
   // Fetches at the bottom, second word and top of the space.
   task automatic t_fetch;
      logic [22:0] pcs [3] = '{23'h000000, 23'h000002, 23'h7fffff};
      foreach (pcs[i]) begin
         op(KIND_FETCH, pcs[i], 16'h0, 3'b0, CLS_OTHER, 5'h0);
         w = mw({1'b0, pcs[i][22:1], 1'b0});
         chk({8'h0, u_dut.resp_instr}, {8'h0, w}, "fetch");
      end
   endtask
   // Every table read shape in configuration space, window enabled.
   task automatic t_table;
      logic [15:0] e;
      apb(1, OFS_TABLE_PAGE, 32'h81, 0, 0);
      apb(1, OFS_CONTROL, 32'h1, 0, 0);
      for (int f = 0; f < 8; f++) begin
         op(KIND_TABLE, 0, 16'hc2f4 | f[15:0] & 16'h1, {1'b0, f[2:1]},
            CLS_OTHER, 5'h0);
         w = mw({8'h81, 16'hc2f4 | f[15:0] & 16'h1});
         if (!f[2]) e = f[1] ? {8'h0, f[0] ? w[15:8] : w[7:0]} : w[15:0];
         else e = (f[1] && f[0]) ? 16'h0 : {8'h0, w[23:16]};
         chk({16'h0, r_data}, {16'h0, e}, "table read");
      end
      op(KIND_TABLE, 0, 16'h0010, 3'b100, CLS_OTHER, 5'h0);
      chk({29'h0, r_wbe}, 32'h3, "low lanes");
      op(KIND_TABLE, 0, 16'h0010, 3'b110, CLS_OTHER, 5'h0);
      chk({29'h0, r_wbe}, 32'h4, "high lanes");
      op(KIND_TABLE, 0, 16'h0011, 3'b111, CLS_OTHER, 5'h0);
      chk({29'h0, r_wbe}, 32'h0, "high byte odd");
   endtask
   // Window reads: cost per class, inside repeat, and misses.
   task automatic t_window;
      apb(1, OFS_WINDOW_PAGE, 32'hc3, 0, 0);
      w = mw({1'b0, 8'hc3, 15'h7ffe});
      for (int c = 0; c < 4; c++) begin
         op(KIND_DATA, 0, 16'hfffe, 3'b0, instr_class_t'(c), 5'h0);
         chk(r_cyc, (c == 0) ? 4 : 3, "window cost");
         chk({16'h0, r_data}, {16'h0, w[15:0]}, "window data");
      end
      for (int r = 16; r < 32; r++) begin
         op(KIND_DATA, 0, 16'h8001, 3'b0, CLS_MOVE, r[4:0]);
         chk(r_cyc, (r[3:0] != 0) ? 4 : 2, "repeat cost");
      end
      op(KIND_DATA, 0, 16'h7ffe, 3'b0, CLS_MOVE, 5'h0);
      chk({31'h0, r_map}, 0, "low half mapped");
      apb(1, OFS_CONTROL, 0, 0, 0);
      op(KIND_DATA, 0, 16'h8000, 3'b0, CLS_MOVE, 5'h0);
      chk({15'h0, r_map, r_data}, 0, "window off");
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {req_valid, req_write, req_high, req_byte, req_pc, req_ea} = '0;
      {in_repeat, rpt_first, rpt_last, rpt_int_exit, rpt_reentry} = '0;
      req_kind = KIND_FETCH;
      req_class = CLS_OTHER;
      req_wdata = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1;
      t_regs();
      t_fetch();
      t_table();
      t_window();
      tally_and_finish();
   end
endmodule // program_space_access_mapper_tb
`default_nettype wire
